// ==== bst_pkg.sv ====
/*
  bst_pkg: constants and types shared by the boundary-scan test port.
  Assumes: it is compiled before the modules that import it.
*/
package bst_pkg;

  // sixteen controller states, held in four bits
  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SH_DR,
    ST_EX1_DR,
    ST_PAU_DR,
    ST_EX2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SH_IR,
    ST_EX1_IR,
    ST_PAU_IR,
    ST_EX2_IR,
    ST_UPD_IR
  } bst_state_e;

  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int CELLS_PER_IO = 3;

  // instruction codes
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_SAMPLE = 4'h1;
  localparam logic [3:0] OP_IDCODE = 4'h2;
  localparam logic [3:0] OP_BYPASS = 4'hF;

  // value after reset of the instruction register
  localparam logic [3:0] IR_RESET = OP_IDCODE;
  // fixed pattern loaded in capture-ir
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // identification field layout
  localparam int ID_MAKER_LSB = 1;
  localparam int ID_MAKER_W = 11;
  localparam int ID_PART_LSB = 12;
  localparam int ID_PART_W = 16;
  localparam int ID_VER_LSB = 28;
  localparam int ID_VER_W = 4;

  // synchroniser depth for signals entering the system clock
  localparam int SYNC_STAGES = 3;

endpackage

// ==== bst_tap.sv ====
/*
  bst_tap: boundary-scan test port with instruction register, bypass,
  identification and boundary-scan data registers.
  Assumes: tck from the tester is the link clock; i_trst is asynchronous and
  active high; I_CLOCK/I_RST form the core domain that uses the scan cells.
*/
`timescale 1ns/1ps
module bst_tap
  import bst_pkg::*;
#(
  parameter int N_IO = 4,
  parameter logic [10:0] MAKER_ID = 11'h055, // arbitrary value
  parameter logic [15:0] PART_ID = 16'h1234, // arbitrary value
  parameter logic [3:0] VERSION_ID = 4'h1 // arbitrary value
)
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst,
  output logic o_tdo,
  output logic o_tdo_oe,
  input wire logic [N_IO-1:0] i_core_out,
  input wire logic [N_IO-1:0] i_core_oe,
  input wire logic [N_IO-1:0] i_pad_in,
  output logic [N_IO-1:0] o_pad_out,
  output logic [N_IO-1:0] o_pad_oe,
  output logic [N_IO-1:0] o_core_in,
  output logic o_test_mode
);
  import bst_pkg::*;

  localparam int BSR_W = CELLS_PER_IO * N_IO;

  bst_state_e st;

  // tck domain state
  typedef struct packed {
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic byp;
    logic [ID_W-1:0] id_sh;
    logic [BSR_W-1:0] bsr_sh;
    logic [BSR_W-1:0] bsr_upd;
  } bst_tck_s;

  // falling-edge tdo stage
  typedef struct packed {
    logic tdo;
    logic oe;
  } bst_neg_s;

  // core domain state: synchronised test-mode flag and registered pad outputs
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync;
    logic mode;
    logic [N_IO-1:0] pout;
    logic [N_IO-1:0] poe;
    logic [N_IO-1:0] cin;
  } bst_core_s;

  bst_tck_s t_q;
  bst_tck_s t_d;
  bst_neg_s n_q;
  bst_neg_s n_d;
  bst_core_s c_q;
  bst_core_s c_d;

  // controller built only from tms, tck and trst
  bst_tap_fsm u_fsm (
    .i_tck(i_tck),
    .i_trst(i_trst),
    .i_tms(i_tms),
    .o_state(st)
  );

  // identification word with marker bit fixed at one
  function automatic logic [ID_W-1:0] id_word();
    logic [ID_W-1:0] w;
    w = '0;
    w[0] = 1'b1;
    w[ID_MAKER_LSB +: ID_MAKER_W] = MAKER_ID;
    w[ID_PART_LSB +: ID_PART_W] = PART_ID;
    w[ID_VER_LSB +: ID_VER_W] = VERSION_ID;
    return w;
  endfunction

  // register select decode; unknown codes fall back to bypass
  function automatic logic [1:0] dr_sel(input logic [IR_W-1:0] ir);
    logic [1:0] r;
    r = 2'h0; // bypass
    case (ir)
      OP_IDCODE: r = 2'h1;
      OP_EXTEST: r = 2'h2;
      OP_SAMPLE: r = 2'h2;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  logic [1:0] sel;
  logic [BSR_W-1:0] bsr_par_in;
  logic extest;

  assign sel = dr_sel(t_q.ir);
  assign extest = (t_q.ir == OP_EXTEST);

  // parallel-in of cells: per pin input, output and enable
  always_comb
  begin
    bsr_par_in = '0;
    for (int i = 0; i < N_IO; i++)
    begin
      bsr_par_in[CELLS_PER_IO*i] = i_pad_in[i];
      bsr_par_in[CELLS_PER_IO*i+1] = i_core_out[i];
      bsr_par_in[CELLS_PER_IO*i+2] = i_core_oe[i];
    end
  end

  // capture, shift and update on rising tck
  always_comb
  begin
    t_d = t_q;
    case (st)
      ST_RESET:
      begin
        t_d.ir = IR_RESET;
      end
      ST_CAP_IR: t_d.ir_sh = IR_CAPTURE;
      ST_SH_IR: t_d.ir_sh = {i_tdi, t_q.ir_sh[IR_W-1:1]};
      ST_UPD_IR: t_d.ir = t_q.ir_sh;
      ST_CAP_DR:
      begin
        t_d.byp = 1'b0;
        t_d.id_sh = id_word();
        t_d.bsr_sh = bsr_par_in;
      end
      ST_SH_DR:
      begin
        case (sel)
          2'h1: t_d.id_sh = {i_tdi, t_q.id_sh[ID_W-1:1]};
          2'h2: t_d.bsr_sh = {i_tdi, t_q.bsr_sh[BSR_W-1:1]};
          default: t_d.byp = i_tdi;
        endcase
      end
      ST_UPD_DR:
      begin
        if (sel == 2'h2)
          t_d.bsr_upd = t_q.bsr_sh;
      end
      default: t_d = t_q;
    endcase
  end

  always_ff @(posedge i_tck or posedge i_trst)
  begin
    if (i_trst)
      t_q <= '{ir_sh: '0, ir: IR_RESET, byp: 1'b0, id_sh: '0, bsr_sh: '0, bsr_upd: '0};
    else
      t_q <= t_d;
  end

  // tdo source mux, enabled only while shifting
  always_comb
  begin
    n_d.oe = (st == ST_SH_IR) || (st == ST_SH_DR);
    n_d.tdo = 1'b0;
    if (st == ST_SH_IR)
      n_d.tdo = t_q.ir_sh[0];
    else if (st == ST_SH_DR)
    begin
      case (sel)
        2'h1: n_d.tdo = t_q.id_sh[0];
        2'h2: n_d.tdo = t_q.bsr_sh[0];
        default: n_d.tdo = t_q.byp;
      endcase
    end
  end

  // falling edge keeps tdo stable across the tester's rising sample
  always_ff @(negedge i_tck or posedge i_trst)
  begin
    if (i_trst)
      n_q <= '{tdo: 1'b0, oe: 1'b0};
    else
      n_q <= n_d;
  end

  assign o_tdo = n_q.tdo;
  assign o_tdo_oe = n_q.oe;

  // core domain: extest level crosses by synchroniser; update cells are quasi-static
  // since they only change in update-dr, long before the mode flag settles
  always_comb
  begin
    c_d = c_q;
    c_d.sync = {c_q.sync[SYNC_STAGES-2:0], extest};
    if (c_q.sync[SYNC_STAGES-1] == c_q.sync[SYNC_STAGES-2])
      c_d.mode = c_q.sync[SYNC_STAGES-1];
    for (int i = 0; i < N_IO; i++)
    begin
      c_d.pout[i] = c_q.mode ? t_q.bsr_upd[CELLS_PER_IO*i+1] : i_core_out[i];
      c_d.poe[i] = c_q.mode ? t_q.bsr_upd[CELLS_PER_IO*i+2] : i_core_oe[i];
      c_d.cin[i] = c_q.mode ? t_q.bsr_upd[CELLS_PER_IO*i] : i_pad_in[i];
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
      c_q <= '{sync: '0, mode: 1'b0, pout: '0, poe: '0, cin: '0};
    else
      c_q <= c_d;
  end

  assign o_pad_out = c_q.pout;
  assign o_pad_oe = c_q.poe;
  assign o_core_in = c_q.cin;
  assign o_test_mode = c_q.mode;
endmodule

// ==== bst_tap_fsm.sv ====
/*
  bst_tap_fsm: the sixteen-state test port controller and its state output.
  Assumes: runs on the link clock; asynchronous active-high test reset.
*/
`timescale 1ns/1ps
module bst_tap_fsm
  import bst_pkg::*;
(
  input wire logic i_tck,
  input wire logic i_trst,
  input wire logic i_tms,
  output bst_pkg::bst_state_e o_state
);
  import bst_pkg::*;

  typedef struct packed {
    bst_state_e st;
  } bst_fsm_s;

  bst_fsm_s s_q;
  bst_fsm_s s_d;

  // next state from tms level only
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      ST_RESET: s_d.st = i_tms ? ST_RESET : ST_IDLE;
      ST_IDLE: s_d.st = i_tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: s_d.st = i_tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: s_d.st = i_tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: s_d.st = i_tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: s_d.st = i_tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: s_d.st = i_tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: s_d.st = i_tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: s_d.st = i_tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: s_d.st = i_tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: s_d.st = i_tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: s_d.st = i_tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: s_d.st = i_tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: s_d.st = i_tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: s_d.st = i_tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: s_d.st = i_tms ? ST_SEL_DR : ST_IDLE;
      default: s_d.st = ST_RESET;
    endcase
  end

  // rising tck samples tms; trst forces reset at once
  always_ff @(posedge i_tck or posedge i_trst)
  begin
    if (i_trst)
      s_q <= '{st: ST_RESET};
    else
      s_q <= s_d;
  end

  assign o_state = s_q.st;
endmodule

// ==== bst_tap_properties.sv ====
/* bst_tap_properties: port-level checks of the boundary-scan test port.
   Assumes: bound to bst_tap; trst resets the link side, I_RST the core side. */
`timescale 1ns/1ps
module bst_tap_properties #(parameter int N_IO = 4)
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_trst,
  input wire logic o_tdo_oe,
  input wire logic [N_IO-1:0] i_core_out,
  input wire logic [N_IO-1:0] i_pad_in,
  input wire logic [N_IO-1:0] o_pad_out,
  input wire logic [N_IO-1:0] o_core_in,
  input wire logic o_test_mode
);
  // link side: the output enable is a view of the shift states only
  property p_tms_hi; @(posedge i_tck) disable iff (i_trst) i_tms |=> !o_tdo_oe; endproperty
  a_tms_hi: assert property (p_tms_hi) else $error("oe after tms high");
  property p_five; @(posedge i_tck) disable iff (i_trst) i_tms [*5] ##1 !i_tms [*2] |=> !o_tdo_oe; endproperty
  a_five: assert property (p_five) else $error("no reset after five");
  // shift is entered from capture or from exit2; both need tms low on the entering edge
  property p_rose; @(posedge i_tck) disable iff (i_trst) $rose(o_tdo_oe) |-> !$past(i_tms); endproperty
  a_rose: assert property (p_rose) else $error("shift entered wrongly");
  property p_fell; @(posedge i_tck) disable iff (i_trst) $fell(o_tdo_oe) |-> $past(i_tms); endproperty
  a_fell: assert property (p_fell) else $error("shift left wrongly");
  property p_hold; @(posedge i_tck) disable iff (i_trst) o_tdo_oe && !i_tms |=> o_tdo_oe; endproperty
  a_hold: assert property (p_hold) else $error("shift dropped");
  // core side: three quiet cycles of mode cover any select skew
  sequence s_normal;
    !o_test_mode && !$past(o_test_mode) && !$past(o_test_mode, 2) && !$past(I_RST);
  endsequence
  property p_pad_out; @(posedge I_CLOCK) disable iff (I_RST) s_normal |-> o_pad_out == $past(i_core_out); endproperty
  a_pad_out: assert property (p_pad_out) else $error("pad out not core");
  property p_core_in; @(posedge I_CLOCK) disable iff (I_RST) s_normal |-> o_core_in == $past(i_pad_in); endproperty
  a_core_in: assert property (p_core_in) else $error("core in not pad");
  property p_trst_mode; @(posedge I_CLOCK) disable iff (I_RST) i_trst [*6] |-> !o_test_mode; endproperty
  a_trst_mode: assert property (p_trst_mode) else $error("mode kept in reset");
  // main scenarios reached
  c_shift: cover property (@(posedge i_tck) $rose(o_tdo_oe));
  c_mode: cover property (@(posedge I_CLOCK) $rose(o_test_mode));
  c_five: cover property (@(posedge i_tck) i_tms [*5]);
endmodule

// ==== bst_tester.sv ====
/* bst_tester: behavioural scan tester; tck runs only inside its tasks.
   Assumes: one caller at a time; tdo moves on falling tck. */
`timescale 1ns/1ps
module bst_tester
(
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // link idles with the clock low and reset released
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst = 1'b0;
  end
  // one 64 ns period; tdi is spoiled after the rise so stale data never looks valid
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #32 tck = 1'b1;
    o = tdo;
    #16 tdi = ~d;
    #16 tck = 1'b0;
  endtask
  // idle to shift, 32 bits lsb first, update, back to idle
  task automatic scan(input logic ir, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    tick(1'b1, 1'b0, o);
    if (ir)
      tick(1'b1, 1'b0, o);
    repeat (2) tick(1'b0, 1'b0, o);
    for (int i = 0; i < 32; i++)
      tick(i == 31, din[i], dout[i]);
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask
  // reset by tms alone, then settle in idle
  task automatic five_ones();
    logic o;
    repeat (5) tick(1'b1, 1'b0, o);
    repeat (2) tick(1'b0, 1'b0, o);
  endtask
  // reset with tck stopped; one edge under reset keeps the link checks clean
  task automatic pulse_trst(output logic oe);
    logic o;
    trst = 1'b1;
    #400 oe = tdo_oe;
    tick(1'b1, 1'b0, o);
    trst = 1'b0;
    tick(1'b0, 1'b0, o);
  endtask
endmodule

// ==== tb.sv ====
/* tb: self-checking bench for bst_tap driven by the behavioural tester.
   Assumes: package, design, tester and checker are compiled first. */
`timescale 1ns/1ps
module tb;
  import bst_pkg::*;
  logic clk, rst, i_tck, i_tms, i_tdi, i_trst, o_tdo, o_tdo_oe, o_test_mode, o;
  logic [3:0] i_core_out, i_core_oe, i_pad_in, o_pad_out, o_pad_oe, o_core_in;
  logic [31:0] dout;
  int mismatches = 0;
  int compares = 0;
  // core clock, 50 ns
  always #25 clk = ~clk;
  bst_tap bst_tap_inst (.I_CLOCK(clk), .I_RST(rst), .i_tck, .i_tms, .i_tdi, .i_trst, .o_tdo, .o_tdo_oe,
    .i_core_out, .i_core_oe, .i_pad_in, .o_pad_out, .o_pad_oe, .o_core_in, .o_test_mode);
  bst_tester bst_tester_inst (.tck(i_tck), .tms(i_tms), .tdi(i_tdi), .trst(i_trst), .tdo(o_tdo), .tdo_oe(o_tdo_oe));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // identification leaves marker bit first
  task automatic t_idcode();
    bst_tester_inst.scan(1'b0, 32'h0000_0000, dout);
    check("idcode", {4'h1, 16'h1234, 11'h055, 1'b1}, dout);
  endtask
  // bypass and an unused code both give a one-bit path that starts at 0
  task automatic t_bypass();
    logic [3:0] ops [2] = '{OP_BYPASS, 4'h5};
    foreach (ops[k])
    begin
      bst_tester_inst.scan(1'b1, {ops[k], 28'h123_4567}, dout);
      check("ir", {28'h123_4567, IR_CAPTURE}, dout);
      bst_tester_inst.scan(1'b0, 32'hA5C3_0F96, dout);
      check("bypass", 32'h4B86_1F2C, dout);
    end
  endtask
  logic ops4 [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  // test reset with tck stopped cuts an instruction shift short
  task automatic t_trst();
    logic oe;
    foreach (ops4[k])
      bst_tester_inst.tick(ops4[k], 1'b0, o);
    bst_tester_inst.pulse_trst(oe);
    check("trst oe", 1'b0, oe);
    t_idcode();
  endtask
  // sample captures pins; extest drives the preloaded cells
  task automatic t_bsr();
    logic [11:0] cap, pre;
    for (int i = 0; i < 4; i++)
    begin
      cap[3*i +: 3] = {i_core_oe[i], i_core_out[i], i_pad_in[i]};
      pre[3*i +: 3] = {~i_core_oe[i], ~i_core_out[i], 1'b0};
    end
    bst_tester_inst.scan(1'b1, {OP_SAMPLE, 28'h000_0000}, dout);
    bst_tester_inst.scan(1'b0, {pre, 20'h0_0000}, dout);
    check("capture", cap, dout[11:0]);
    bst_tester_inst.scan(1'b1, {OP_EXTEST, 28'h000_0000}, dout);
    repeat (8) @(negedge clk);
    check("extest", {1'b1, 4'h0, 4'hC, 4'hA}, {o_test_mode, o_core_in, o_pad_oe, o_pad_out});
  endtask
  // five high tms from mid shift end extest and restore identification
  task automatic t_five();
    // idle, select-dr, capture-dr, then into shift-dr
    bst_tester_inst.tick(1'b1, 1'b0, o);
    bst_tester_inst.tick(1'b0, 1'b0, o);
    bst_tester_inst.tick(1'b0, 1'b0, o);
    #1 check("oe", 1'b1, o_tdo_oe);
    bst_tester_inst.five_ones();
    repeat (8) @(negedge clk);
    check("normal", {1'b0, 4'hA, 4'h3, 4'h5}, {o_test_mode, o_core_in, o_pad_oe, o_pad_out});
    t_idcode();
  endtask
  // both resets, then the scenarios
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    i_core_out = 4'h5;
    i_core_oe = 4'h3;
    i_pad_in = 4'hA;
    @(negedge clk);
    bst_tester_inst.pulse_trst(o);
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_idcode();
    t_bypass();
    t_trst();
    t_bsr();
    t_five();
    close_out();
  end
  // watchdog: the run needs well under 60 us
  initial
  begin
    #200000;
    mismatches++;
    close_out();
  end
endmodule
bind bst_tap bst_tap_properties #(.N_IO(N_IO)) bst_tap_properties_inst (.I_CLOCK, .I_RST, .i_tck, .i_tms,
  .i_trst, .o_tdo_oe, .i_core_out, .i_pad_in, .o_pad_out, .o_core_in, .o_test_mode);
